// [sim/mdio_extended_register_access_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  fails++; $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module mdio_extended_register_access_tb
  import mdioex_pkg::*;
;
  // strap value is arbitrary
  localparam logic [4:0] PHY = 5'h05;
  logic clk_sys;
  logic resetn;
  logic clk_en;
  logic mdc;
  logic mdio_i;
  logic mdio_o;
  logic mdio_oe;
  logic ext_wr;
  logic ext_rd;
  logic [15:0] ext_addr;
  logic [15:0] ext_wdata;
  logic [15:0] ext_rdata;
  logic [15:0] xmem [0:255];
  logic [15:0] rdv;
  logic [1:0] tav;
  int fails;
  int n_compared;
  int n_wr;
  int n_rd;

  mdioex_top u_mdioex_top (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
    .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .phy_address_straps(PHY),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_wr(ext_wr),
    .ext_rd(ext_rd), .ext_rdata(ext_rdata)
  );

  mdioex_station u_mdioex_station (
    .clk_sys(clk_sys), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .mdc(mdc), .mdio_i(mdio_i)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // extended space stand-in; read data moves half a clock after the address
  always @(negedge clk_sys) begin
    ext_rdata <= xmem[ext_addr[7:0]];
  end
  always @(posedge clk_sys) begin
    if (ext_wr === 1'b1) begin
      xmem[ext_addr[7:0]] <= ext_wdata;
      n_wr++;
    end
    if (ext_rd === 1'b1) begin
      n_rd++;
    end
  end

  function automatic logic [15:0] pat(input logic [7:0] a);
    pat = {8'hA5, a};
  endfunction : pat

  task report_and_stop;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task wr(input logic [4:0] rg, input logic [15:0] d);
    u_mdioex_station.frame(OP_WRITE, PHY, rg, d, rdv, tav);
  endtask : wr

  task rdc(input logic [4:0] rg, input logic [15:0] exp);
    u_mdioex_station.frame(OP_READ, PHY, rg, 16'h0000, rdv, tav);
    `CHK(tav, 2'b10)
    `CHK(rdv, exp)
  endtask : rdc

  // hang guard well beyond the longest sequence
  initial begin
    #2_000_000;
    fails++;
    report_and_stop();
  end

  initial begin
    fails = 0;
    n_compared = 0;
    n_wr = 0;
    n_rd = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    for (int i = 0; i < 256; i++) begin
      xmem[i] = pat(i[7:0]);
    end
    // four rising edges pass with reset held low
    repeat (4) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (12) @(negedge clk_sys);
    // reset state; window ignored while device select is 0
    rdc(REG_ACCESS_CTRL, 16'h0000);
    rdc(REG_WINDOW, 16'h0000);
    // direct access and address filtering
    wr(5'h03, 16'h1234);
    u_mdioex_station.frame(OP_WRITE, PHY ^ 5'h01, 5'h03, 16'hFFFF, rdv, tav);
    u_mdioex_station.frame(OP_READ, PHY ^ 5'h01, 5'h03, 16'h0, rdv, tav);
    `CHK(rdv, 16'hFFFF)
    rdc(5'h03, 16'h1234);
    // a frozen block sees no clock edges, so the whole frame is lost
    clk_en = 1'b0;
    wr(5'h03, 16'hBEEF);
    clk_en = 1'b1;
    rdc(5'h03, 16'h1234);
    // opcodes 00 and 11 are walked but not acted on
    for (int k = 0; k < 4; k += 3) begin
      u_mdioex_station.frame(k[1:0], PHY, 5'h03, 16'hDEAD, rdv, tav);
    end
    rdc(5'h03, 16'h1234);
    // address function, later writes keep loading the address
    wr(REG_ACCESS_CTRL, 16'h001F);
    wr(REG_WINDOW, 16'h0170);
    wr(REG_WINDOW, 16'h0171);
    rdc(REG_WINDOW, 16'h0171);
    `CHK(ext_addr, 16'h0171)
    // data without increment
    wr(REG_ACCESS_CTRL, 16'h401F);
    wr(REG_WINDOW, 16'h0C50);
    wr(REG_WINDOW, 16'h0AAA);
    rdc(REG_WINDOW, 16'h0AAA);
    rdc(REG_WINDOW, 16'h0AAA);
    `CHK(xmem[8'h71], 16'h0AAA)
    `CHK(xmem[8'h70], pat(8'h70))
    // increment after reads and writes
    wr(REG_ACCESS_CTRL, 16'h001F);
    wr(REG_WINDOW, 16'h0180);
    wr(REG_ACCESS_CTRL, 16'h801F);
    rdc(REG_WINDOW, pat(8'h80));
    rdc(REG_WINDOW, pat(8'h81));
    wr(REG_WINDOW, 16'h1111);
    `CHK(xmem[8'h82], 16'h1111)
    wr(REG_ACCESS_CTRL, 16'h001F);
    rdc(REG_WINDOW, 16'h0183);
    // increment after writes only, address setup skipped
    wr(REG_ACCESS_CTRL, 16'hC01F);
    rdc(REG_WINDOW, pat(8'h83));
    rdc(REG_WINDOW, pat(8'h83));
    wr(REG_WINDOW, 16'h2222);
    wr(REG_WINDOW, 16'h3333);
    `CHK(xmem[8'h83], 16'h2222)
    `CHK(xmem[8'h84], 16'h3333)
    wr(REG_ACCESS_CTRL, 16'h001F);
    rdc(REG_WINDOW, 16'h0185);
    // standard register through the window
    wr(REG_WINDOW, 16'h0003);
    wr(REG_ACCESS_CTRL, 16'h401F);
    rdc(REG_WINDOW, 16'h1234);
    wr(REG_WINDOW, 16'h5678);
    rdc(5'h03, 16'h5678);
    // the control register is not reachable indirectly
    wr(REG_ACCESS_CTRL, 16'h001F);
    wr(REG_WINDOW, 16'h000D);
    wr(REG_ACCESS_CTRL, 16'h401F);
    wr(REG_WINDOW, 16'h1234);
    rdc(REG_ACCESS_CTRL, 16'h401F);
    rdc(REG_WINDOW, 16'h0000);
    // wrong device select leaves the address alone
    wr(REG_ACCESS_CTRL, 16'h001E);
    wr(REG_WINDOW, 16'h0200);
    rdc(REG_ACCESS_CTRL, 16'h001E);
    rdc(REG_WINDOW, 16'h0000);
    wr(REG_ACCESS_CTRL, 16'h001F);
    rdc(REG_WINDOW, 16'h000D);
    // only accesses that reach the extended space show on its port
    `CHK(n_wr, 5)
    `CHK(n_rd, 6)
    report_and_stop();
  end
endmodule : mdio_extended_register_access_tb
`default_nettype wire

// [sim/mdioex_station.sv]
`timescale 1ns/1ps
`default_nettype none
module mdioex_station (
  // clocking
  input wire logic clk_sys,
  // device side of the data line
  input wire logic mdio_o,
  input wire logic mdio_oe,
  // management clock and resolved data line
  output logic mdc,
  output logic mdio_i
);
  logic drv_en;
  logic drv_val;

  // pull-up wins whenever nobody drives the line
  assign mdio_i = mdio_oe ? mdio_o : (drv_en ? drv_val : 1'b1);

  initial begin
    mdc = 1'b0;
    drv_en = 1'b1;
    drv_val = 1'b1;
  end

  // one 200 ns bit: data moves while mdc is low, sampled at the rise
  task bit_slot(input logic drive, input logic val, output logic smp);
    @(negedge clk_sys);
    mdc = 1'b0;
    drv_en = drive;
    drv_val = val;
    repeat (3) @(negedge clk_sys);
    smp = mdio_i;
    mdc = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask : bit_slot

  // whole frame; the clock stands still low once it is over
  task frame(input logic [1:0] op, input logic [4:0] phy,
             input logic [4:0] rg, input logic [15:0] wd,
             output logic [15:0] rd, output logic [1:0] ta);
    logic [13:0] hdr;
    logic s;
    logic rdop;
    hdr = {2'b01, op, phy, rg};
    rdop = (op == 2'b10);
    bit_slot(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) begin
      bit_slot(1'b1, hdr[i], s);
    end
    // read turnaround is released, write turnaround is driven 10
    bit_slot(!rdop, 1'b1, ta[1]);
    bit_slot(!rdop, 1'b0, ta[0]);
    for (int i = 15; i >= 0; i--) begin
      bit_slot(!rdop, wd[i], s);
      rd[i] = s;
    end
    @(negedge clk_sys);
    mdc = 1'b0;
    drv_en = 1'b1;
    drv_val = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask : frame
endmodule : mdioex_station
`default_nettype wire

// [verilog/mdioex_pkg.sv]
package mdioex_pkg;

  // direct register offsets of the two extended access registers
  localparam logic [4:0] REG_ACCESS_CTRL = 5'h0D;
  localparam logic [4:0] REG_WINDOW = 5'h0E;

  // frame opcodes
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  // access functions held in control bits 15:14
  localparam logic [1:0] FN_ADDR = 2'h0;
  localparam logic [1:0] FN_DATA = 2'h1;
  localparam logic [1:0] FN_INC_RW = 2'h2;
  localparam logic [1:0] FN_INC_WR = 2'h3;

  // field positions inside the access control register
  localparam int FN_MSB = 15;
  localparam int FN_LSB = 14;
  localparam int DEVSEL_MSB = 4;
  localparam int DEVSEL_LSB = 0;

  // the only managed device served by the window
  localparam logic [4:0] DEVSEL_VENDOR = 5'h1F;

  // reset values and the window address step
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] WIN_INC = 16'h0001;

  // last bit index of each frame field (count starts at zero)
  localparam logic [4:0] OP_LAST = 5'h01;
  localparam logic [4:0] PHY_LAST = 5'h04;
  localparam logic [4:0] REG_LAST = 5'h04;
  localparam logic [4:0] TA_LAST = 5'h01;
  localparam logic [4:0] DATA_LAST = 5'h0F;

  // sys clocks after reset release before straps are caught
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_OP,
    ST_PHY,
    ST_REG,
    ST_TA,
    ST_DATA
  } mdioex_state_e;

  // last bit index of the field that a state collects
  function automatic logic [4:0] mdioex_field_last(input mdioex_state_e st);
    case (st)
      ST_OP: mdioex_field_last = OP_LAST;
      ST_PHY: mdioex_field_last = PHY_LAST;
      ST_REG: mdioex_field_last = REG_LAST;
      ST_TA: mdioex_field_last = TA_LAST;
      default: mdioex_field_last = DATA_LAST;
    endcase
  endfunction : mdioex_field_last

  // extended address that lands on a standard register 0..31
  function automatic logic mdioex_is_std(input logic [15:0] a);
    mdioex_is_std = (a[15:5] == 11'h000);
  endfunction : mdioex_is_std

  // the two access registers are never reached indirectly
  function automatic logic mdioex_std_ok(input logic [15:0] a);
    mdioex_std_ok = mdioex_is_std(a) && (a[4:0] != REG_ACCESS_CTRL)
                    && (a[4:0] != REG_WINDOW);
  endfunction : mdioex_std_ok

endpackage : mdioex_pkg

// [verilog/mdioex_regmem.sv]
`timescale 1ns/1ps
`default_nettype none
module mdioex_regmem #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 16,
  parameter int AW = 5
) (
  // clocking
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // registered read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] valid_r;
  logic [WIDTH-1:0] rdata_r;

  // array has no reset; words never written read as zero
  always_ff @(posedge clk_sys) begin
    if (clk_en && we) begin
      mem[waddr] <= wdata;
    end
  end

  // written flags and read register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      valid_r <= '0;
      rdata_r <= '0;
    end else if (clk_en) begin
      if (we) begin
        valid_r[waddr] <= 1'b1;
      end
      rdata_r <= valid_r[raddr] ? mem[raddr] : '0;
    end
  end

  assign rdata = rdata_r;

endmodule : mdioex_regmem
`default_nettype wire

// [verilog/mdioex_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module mdioex_sync #(
  parameter int WIDTH = 7
) (
  // clocking
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;

  // two stages; only the second stage reads the first
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_r <= '0;
      s2_r <= '0;
    end else if (clk_en) begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;

endmodule : mdioex_sync
`default_nettype wire

// [verilog/mdioex_top.sv]
// Operation
// - frame is idle, 01, opcode, addresses, turnaround, data
// - extended space reached via registers 0x0D, 0x0E
// - registers 0..31 reachable directly and indirectly
// - indirect access to 0x0D, 0x0E is ignored
// - control bits 4:0 select the managed device
// - window ignored unless device select is 11111
// - function 00 makes window the address register
// - function 01 accesses data, address unchanged
// - function 10 increments after reads and writes
// - function 11 increments after writes only
// - with 0x001F, window writes load the address
// - with 0x001F, window read returns the address
// - repeated non-incrementing writes hit one register
// - repeated non-incrementing reads return one register
// - turnaround bit one undriven, bit two zero
// - data line sampled on management clock rising edge
// - address caught from straps, only matching frames answered
`timescale 1ns/1ps
`default_nettype none
module mdioex_top
  import mdioex_pkg::*;
(
  // clocking
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // management serial port
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  // address straps
  input wire logic [4:0] phy_address_straps,
  // extended register space outside this block
  output logic [15:0] ext_addr,
  output logic [15:0] ext_wdata,
  output logic ext_wr,
  output logic ext_rd,
  input wire logic [15:0] ext_rdata
);

  logic [6:0] sync_q;
  logic mdc_s;
  logic mdio_s;
  logic [4:0] straps_s;
  logic mdc_prev_r;
  logic [1:0] strap_cnt_r;
  logic strap_done_r;
  logic [4:0] phy_addr_r;
  mdioex_state_e state_r;
  mdioex_state_e state_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [15:0] sh_r;
  logic [1:0] op_r;
  logic phy_hit_r;
  logic [4:0] reg_r;
  logic [15:0] rdsh_r;
  logic mdio_o_r;
  logic mdio_oe_r;
  logic [15:0] ctrl_r;
  logic [15:0] addr_r;
  logic [15:0] ext_addr_r;
  logic [15:0] ext_wdata_r;
  logic ext_wr_r;
  logic ext_rd_r;
  logic [15:0] mem_rdata;

  // pins and straps cross into the system clock
  mdioex_sync #(
    .WIDTH(7)
  ) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .d({mdc, mdio_i, phy_address_straps}),
    .q(sync_q)
  );

  assign mdc_s = sync_q[6];
  assign mdio_s = sync_q[5];
  assign straps_s = sync_q[4:0];

  // rising edge of the management clock, once straps are known
  wire rise = clk_en && strap_done_r && mdc_s && !mdc_prev_r;
  wire cnt_last = (cnt_r == mdioex_field_last(state_r));
  wire [15:0] wdata_w = {sh_r[14:0], mdio_s};
  wire rd_hit = phy_hit_r && (op_r == OP_READ);
  wire wr_hit = phy_hit_r && (op_r == OP_WRITE);
  wire data_last = rise && (state_r == ST_DATA) && cnt_last;
  wire rd_evt = data_last && rd_hit;
  wire wr_evt = data_last && wr_hit;
  wire ta_first = rise && (state_r == ST_TA) && (cnt_r == 5'h00);

  // access register decode
  wire is_ctl = (reg_r == REG_ACCESS_CTRL);
  wire is_win = (reg_r == REG_WINDOW);
  wire [1:0] fn = ctrl_r[FN_MSB:FN_LSB];
  wire dev_ok = (ctrl_r[DEVSEL_MSB:DEVSEL_LSB] == DEVSEL_VENDOR);
  wire win_addr = is_win && dev_ok && (fn == FN_ADDR);
  wire win_data = is_win && dev_ok && (fn != FN_ADDR);
  wire tgt_std = mdioex_is_std(addr_r);
  wire tgt_ok = mdioex_std_ok(addr_r);

  // address step after a completed window access
  wire inc_wr = wr_evt && win_data && fn[1];
  wire inc_rd = rd_evt && win_data && (fn == FN_INC_RW);
  wire addr_ld = wr_evt && win_addr;

  // standard register writes, direct or through the window
  wire dir_we = wr_evt && !is_ctl && !is_win;
  wire ind_we = wr_evt && win_data && tgt_ok;
  wire mem_we = dir_we || ind_we;
  wire [4:0] mem_waddr = ind_we ? addr_r[4:0] : reg_r;
  wire [4:0] mem_raddr = is_win ? addr_r[4:0] : reg_r;

  // value returned by a read frame
  wire [15:0] win_rd = !tgt_std ? ext_rdata :
                       tgt_ok ? mem_rdata : 16'h0000;
  wire [15:0] rd_value = is_ctl ? ctrl_r :
                         win_addr ? addr_r :
                         win_data ? win_rd :
                         is_win ? 16'h0000 : mem_rdata;

  mdioex_regmem #(
    .DEPTH(32),
    .WIDTH(16),
    .AW(5)
  ) u_regs (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(wdata_w),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // edge history and strap capture; straps are held steady at reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mdc_prev_r <= 1'b0;
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
      phy_addr_r <= 5'h00;
    end else if (clk_en) begin
      mdc_prev_r <= mdc_s;
      if (!strap_done_r) begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
        if (strap_cnt_r == STRAP_WAIT) begin
          phy_addr_r <= straps_s;
          strap_done_r <= 1'b1;
        end
      end
    end
  end

  // frame sequencer; frames not for us still run to the end
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (rise) begin
      case (state_r)
        ST_IDLE: begin
          if (!mdio_s) begin
            state_nxt = ST_START;
          end
        end
        ST_START: begin
          state_nxt = mdio_s ? ST_OP : ST_IDLE;
          cnt_nxt = 5'h00;
        end
        default: begin
          cnt_nxt = cnt_last ? 5'h00 : cnt_r + 5'h01;
          if (cnt_last) begin
            case (state_r)
              ST_OP: state_nxt = ST_PHY;
              ST_PHY: state_nxt = ST_REG;
              ST_REG: state_nxt = ST_TA;
              ST_TA: state_nxt = ST_DATA;
              default: state_nxt = ST_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // field capture, msb first
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sh_r <= 16'h0000;
      op_r <= 2'h0;
      phy_hit_r <= 1'b0;
      reg_r <= 5'h00;
    end else if (rise) begin
      sh_r <= wdata_w;
      if (cnt_last && state_r == ST_OP) begin
        op_r <= wdata_w[1:0];
      end
      if (cnt_last && state_r == ST_PHY) begin
        phy_hit_r <= (wdata_w[4:0] == phy_addr_r);
      end
      if (cnt_last && state_r == ST_REG) begin
        reg_r <= wdata_w[4:0];
      end
    end
  end

  // read drive: released in ta bit one, zero in bit two, then data
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mdio_o_r <= 1'b0;
      mdio_oe_r <= 1'b0;
      rdsh_r <= 16'h0000;
    end else if (rise) begin
      if (ta_first && rd_hit) begin
        mdio_oe_r <= 1'b1;
        mdio_o_r <= 1'b0;
        rdsh_r <= rd_value;
      end else if (mdio_oe_r && data_last) begin
        mdio_oe_r <= 1'b0;
      end else if (mdio_oe_r) begin
        mdio_o_r <= rdsh_r[15];
        rdsh_r <= {rdsh_r[14:0], 1'b0};
      end
    end
  end

  // access control and extended address registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RESET;
      addr_r <= ADDR_RESET;
    end else if (clk_en) begin
      if (wr_evt && is_ctl) begin
        ctrl_r <= wdata_w;
      end
      if (addr_ld) begin
        addr_r <= wdata_w;
      end else if (inc_wr || inc_rd) begin
        addr_r <= addr_r + WIN_INC;
      end
    end
  end

  // extended space strobes; address lags one cycle so a write
  // pulse still carries the pre-increment target
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_addr_r <= ADDR_RESET;
      ext_wdata_r <= 16'h0000;
      ext_wr_r <= 1'b0;
      ext_rd_r <= 1'b0;
    end else if (clk_en) begin
      ext_addr_r <= addr_r;
      ext_wr_r <= wr_evt && win_data && !tgt_std;
      ext_rd_r <= rd_evt && win_data && !tgt_std;
      if (wr_evt) begin
        ext_wdata_r <= wdata_w;
      end
    end
  end

  assign mdio_o = mdio_o_r;
  assign mdio_oe = mdio_oe_r;
  assign ext_addr = ext_addr_r;
  assign ext_wdata = ext_wdata_r;
  assign ext_wr = ext_wr_r;
  assign ext_rd = ext_rd_r;

  // checks
  a_oe_read_only: assert property (@(posedge clk_sys)
    disable iff (!resetn) mdio_oe_r |-> rd_hit
      && (state_r == ST_TA || state_r == ST_DATA))
    else $error("data line driven outside a matching read");
  a_ta_drive_zero: assert property (@(posedge clk_sys)
    disable iff (!resetn) $rose(mdio_oe_r) |-> !mdio_o_r && state_r == ST_TA)
    else $error("second turnaround bit not driven low");
  a_ta_first_free: assert property (@(posedge clk_sys)
    disable iff (!resetn) (rise && state_r == ST_REG && cnt_last)
    |=> !mdio_oe_r)
    else $error("first turnaround bit driven");
  a_fn01_addr_hold: assert property (@(posedge clk_sys)
    disable iff (!resetn) ((wr_evt || rd_evt) && is_win && fn == FN_DATA)
    |=> $stable(addr_r))
    else $error("address moved in non-incrementing data access");
  a_fn10_step: assert property (@(posedge clk_sys)
    disable iff (!resetn) ((wr_evt || rd_evt) && is_win && dev_ok
      && fn == FN_INC_RW) |=> addr_r == $past(addr_r) + WIN_INC)
    else $error("address not stepped after access");
  a_fn11_write_step: assert property (@(posedge clk_sys)
    disable iff (!resetn) (wr_evt && is_win && dev_ok && fn == FN_INC_WR)
    |=> addr_r == $past(addr_r) + WIN_INC)
    else $error("address not stepped after write");
  a_fn11_read_hold: assert property (@(posedge clk_sys)
    disable iff (!resetn) (rd_evt && is_win && fn == FN_INC_WR)
    |=> $stable(addr_r))
    else $error("address moved after read in write-step mode");
  a_addr_load: assert property (@(posedge clk_sys)
    disable iff (!resetn) (wr_evt && is_win && dev_ok && fn == FN_ADDR)
    |=> addr_r == $past(wdata_w) && !ext_wr_r)
    else $error("window write did not load address");
  a_addr_readback: assert property (@(posedge clk_sys)
    disable iff (!resetn) (ta_first && rd_hit && win_addr)
    |=> rdsh_r == $past(addr_r))
    else $error("address readback wrong");
  a_ctrl_guard: assert property (@(posedge clk_sys)
    disable iff (!resetn) (wr_evt && win_data && tgt_std && !tgt_ok)
    |-> !mem_we ##1 ($stable(ctrl_r) && !ext_wr_r))
    else $error("indirect write reached access registers");
  a_dev_ignore: assert property (@(posedge clk_sys)
    disable iff (!resetn) ((wr_evt || rd_evt) && is_win && !dev_ok)
    |=> $stable(addr_r) && !ext_wr_r && !ext_rd_r)
    else $error("window acted with wrong device select");
  a_edge_only: assert property (@(posedge clk_sys)
    disable iff (!resetn) !rise |=> $stable(state_r) && $stable(cnt_r))
    else $error("sequencer moved without clock edge");

endmodule : mdioex_top
`default_nettype wire
